/* rtl/twe_eeprom_dev.sv */
// EEPROM end of the two-wire link
`timescale 1ns/1ns
`include "twe_defs.svh"
module twe_eeprom_dev import twe_pkg::*; #(
	parameter int ADDR_BITS = `TWE_ADDR_BITS,
	parameter int PROG_CYC = `TWE_PROG_CYC
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	twe_link_if.device link,
	output logic [7:0] wrData,
	output logic [14:0] wrAddr,
	output logic wrValid,
	input wire logic wrReady,
	output logic programming
);
	localparam int MEM = 1 << ADDR_BITS;
	logic [7:0] mem [0:MEM-1];
	logic [2:0] sclSync, sdaSync;
	logic sclPrev, sdaPrev;
	twe_dev_state_t state;
	logic [3:0] bitCnt;
	logic [7:0] shift;
	logic [1:0] byteIdx;
	logic isRead, isWrite;
	logic [14:0] addrCnt;
	logic [31:0] progCnt;
	logic pendWrite;
	logic sdaDrive;
	// Two-entry buffer
	logic [22:0] bufData [0:1];
	logic bufWr, bufRd;
	logic [1:0] bufCount;

	////////////////////////////////////////////////////////////////
	wire sclNow = (sclSync[2] == sclSync[1]) ? sclSync[1] : sclPrev;
	wire sdaNow = (sdaSync[2] == sdaSync[1]) ? sdaSync[1] : sdaPrev;
	wire sclRise = sclNow && !sclPrev;
	wire sclFall = !sclNow && sclPrev;
	wire startEv = sclNow && sclPrev && sdaPrev && !sdaNow;
	wire stopEv = sclNow && sclPrev && !sdaPrev && sdaNow;
	wire busy = progCnt != 32'h0;
	wire [14:0] addrMask = 15'((MEM - 1));
	wire [7:0] rxByte = {shift[6:0], sdaNow};
	wire addrMatch = rxByte[7:4] == `TWE_TYPE_CODE;
	wire [14:0] pageInc = {addrCnt[14:`TWE_PAGE_BITS], 6'(addrCnt[5:0] + 6'h1)};
	wire [14:0] readInc = 15'(addrCnt + 15'h1) & addrMask;
	wire [7:0] rdByte = mem[addrCnt & addrMask];
	wire bufFull = bufCount == 2'h2;
	assign bufWr = clkEn && state == DS_RECV && sclRise && bitCnt == 4'h7
		&& isWrite && byteIdx == 2'h3 && !bufFull;
	assign bufRd = clkEn && wrValid && wrReady;
	assign wrValid = bufCount != 2'h0;
	assign wrData = bufData[0][7:0];
	assign wrAddr = bufData[0][22:8];
	assign programming = busy;
	assign link.sdaDevOut = 1'b0;
	assign link.sdaDevOe = sdaDrive;

	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclSync <= 3'h7;
			sdaSync <= 3'h7;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else if (clkEn) begin
			sclSync <= {sclSync[1:0], link.sclLine};
			sdaSync <= {sdaSync[1:0], link.sdaLine};
			sclPrev <= sclNow;
			sdaPrev <= sdaNow;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bufCount <= 2'h0;
		end else begin
			bufCount <= 2'(bufCount + {1'b0, bufWr} - {1'b0, bufRd});
		end
	end

	always_ff @(posedge mclk) begin
		if (bufRd) begin
			bufData[0] <= bufData[1];
		end
		if (bufWr) begin
			bufData[(bufRd || bufCount == 2'h0) ? 0 : (bufCount == 2'h2 ? 1 : 1)]
				<= {addrCnt, rxByte};
		end
		if (bufWr && bufRd && bufCount == 2'h1) begin
			bufData[0] <= {addrCnt, rxByte};
		end
		if (bufRd) begin
			mem[wrAddr & addrMask] <= wrData;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= DS_IDLE;
			bitCnt <= 4'h0;
			shift <= 8'h0;
			byteIdx <= 2'h0;
			isRead <= 1'b0;
			isWrite <= 1'b0;
			addrCnt <= 15'h0;
			progCnt <= 32'h0;
			pendWrite <= 1'b0;
			sdaDrive <= 1'b0;
		end else if (clkEn) begin
			if (busy) begin
				progCnt <= progCnt - 32'h1;
			end
			if (busy) begin
				state <= DS_IDLE;
				sdaDrive <= 1'b0;
			end else if (stopEv) begin
				state <= DS_IDLE;
				sdaDrive <= 1'b0;
				if (pendWrite) begin
					progCnt <= 32'(PROG_CYC);
				end
				pendWrite <= 1'b0;
			end else if (startEv) begin
				state <= DS_RECV;
				bitCnt <= 4'h0;
				byteIdx <= 2'h0;
				isRead <= 1'b0;
				isWrite <= 1'b0;
				sdaDrive <= 1'b0;
			end else begin
				case (state)
				DS_RECV: begin
					if (sclRise) begin
						shift <= rxByte;
						bitCnt <= 4'(bitCnt + 4'h1);
						if (bitCnt == 4'h7) begin
							if (byteIdx == 2'h0 && !addrMatch) begin
								state <= DS_IDLE;
							end else if (isWrite && byteIdx == 2'h3 && bufFull) begin
								state <= DS_RECV;
							end else begin
								state <= DS_ACK;
							end
						end
					end
				end
				DS_ACK: begin
					if (sclFall && !sdaDrive) begin
						sdaDrive <= 1'b1;
						if (byteIdx == 2'h0) begin
							isRead <= shift[0];
							isWrite <= !shift[0];
						end else if (byteIdx == 2'h1) begin
							addrCnt <= {shift[6:0], addrCnt[7:0]} & addrMask;
						end else if (byteIdx == 2'h2) begin
							addrCnt <= {addrCnt[14:8], shift} & addrMask;
						end else begin
							addrCnt <= pageInc;
							pendWrite <= 1'b1;
						end
					end else if (sclFall && sdaDrive) begin
						bitCnt <= 4'h0;
						if (isRead) begin
							state <= DS_SEND;
							shift <= rdByte;
							sdaDrive <= !rdByte[7];
						end else begin
							state <= DS_RECV;
							sdaDrive <= 1'b0;
							byteIdx <= (byteIdx == 2'h3) ? 2'h3 : 2'(byteIdx + 2'h1);
						end
					end
				end
				DS_SEND: begin
					if (sclFall) begin
						bitCnt <= 4'(bitCnt + 4'h1);
						if (bitCnt == 4'h7) begin
							state <= DS_MACK;
							sdaDrive <= 1'b0;
							addrCnt <= readInc;
						end else begin
							shift <= {shift[6:0], 1'b0};
							sdaDrive <= !shift[6];
						end
					end
				end
				DS_MACK: begin
					if (sclRise && sdaNow) begin
						state <= DS_IDLE;
					end else if (sclFall) begin
						state <= DS_SEND;
						bitCnt <= 4'h0;
						shift <= rdByte;
						sdaDrive <= !rdByte[7];
					end
				end
				default: begin
					sdaDrive <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule

/* rtl/twe_defs.svh */
// Constants of the two-wire EEPROM link, both ends
// Operation
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop, idle
// - 8-bit words MSB first, ninth-clock acknowledge
// - Idle at power-up and after stop
// - Controller recovers by clocking nine times (not done by this controller)
// - Device-type code checked in address word
// - Controller sends zero in unused bits
// - Address LSB one reads, zero writes
// - Match acknowledges, mismatch returns idle
// - Byte write: two address bytes, data, stop
// - Write stop starts timed programming, deaf
// - Page write up to 64 bytes
// - Write increments low six bits only
// - Poll by address until programming done
// - Counter holds last address plus one
// - Read counter wraps end to start
// - Current read: byte out, no ack, stop
// - Random read: dummy write, repeated start
// - Sequential read continues while acknowledged
// - Small variant ignores top address bit
// - Fifteen or fourteen bit word address
// - Sample on rising, change after falling
`ifndef TWE_DEFS_SVH
`define TWE_DEFS_SVH
`define TWE_TYPE_CODE 4'h5
`define TWE_PAGE_BITS 6
`define TWE_ADDR_BITS 15
`define TWE_PROG_NS 5000000
`define TWE_CLK_NS 40
`define TWE_PROG_CYC ((`TWE_PROG_NS + `TWE_CLK_NS - 1) / `TWE_CLK_NS)
`define TWE_SCL_DIV 4
`endif

/* rtl/twe_pkg.sv */
// State types, one for each end
package twe_pkg;
	typedef enum logic [4:0] {
		DS_IDLE = 5'h01,
		DS_RECV = 5'h02,
		DS_ACK = 5'h04,
		DS_SEND = 5'h08,
		DS_MACK = 5'h10
	} twe_dev_state_t;
	typedef enum logic [6:0] {
		HS_IDLE = 7'h01,
		HS_START = 7'h02,
		HS_BIT = 7'h04,
		HS_ACK = 7'h08,
		HS_STOP = 7'h10,
		HS_RSTART = 7'h20,
		HS_DONE = 7'h40
	} twe_host_state_t;
endpackage

/* rtl/twe_link_if.sv */
// Two-wire link between controller and EEPROM
`timescale 1ns/1ns
interface twe_link_if;
	logic sclOut;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;
	wire sclLine = sclOut;
	wire sdaLine = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
	modport host (output sclOut, output sdaHostOut, output sdaHostOe, input sclLine, input sdaLine);
	modport device (output sdaDevOut, output sdaDevOe, input sclLine, input sdaLine);
endinterface

/* rtl/twe_host_ctrl.sv */
// Controller end of the two-wire link
`timescale 1ns/1ns
`include "twe_defs.svh"
module twe_host_ctrl import twe_pkg::*; #(
	parameter int SCL_DIV = `TWE_SCL_DIV
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clkEn,
	twe_link_if.host link,
	input wire logic cmdValid,
	output logic cmdReady,
	input wire logic cmdRead,
	input wire logic [7:0] cmdDevAddr,
	input wire logic [14:0] cmdWordAddr,
	input wire logic [7:0] cmdData,
	input wire logic cmdSetAddr,
	output logic [7:0] rdData,
	output logic rdValid,
	input wire logic rdReady,
	output logic nackSeen
);
	twe_host_state_t state;
	logic [7:0] divCnt;
	logic [1:0] phase;
	logic [3:0] bitCnt;
	logic [1:0] byteIdx;
	logic [7:0] shift;
	logic [7:0] dataReg;
	logic [14:0] addrReg;
	logic [7:0] devReg;
	logic readReg, setReg, second, rxPhase;
	logic [2:0] sdaSync;
	logic sdaPrev;
	logic sclOut, sdaOut;

	////////////////////////////////////////////////////////////////
	wire tick = clkEn && divCnt == 8'(SCL_DIV - 1);
	wire sdaNow = (sdaSync[2] == sdaSync[1]) ? sdaSync[1] : sdaPrev;
	assign cmdReady = state == HS_IDLE && !rdValid;
	assign link.sclOut = sclOut;
	assign link.sdaHostOut = 1'b0;
	assign link.sdaHostOe = !sdaOut;
	wire [7:0] nextByte = (byteIdx == 2'h0) ? ((second) ? {devReg[7:1], 1'b1}
		: {devReg[7:1], readReg && !setReg})
		: (byteIdx == 2'h1) ? {1'b0, addrReg[14:8]}
		: (byteIdx == 2'h2) ? addrReg[7:0] : dataReg;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sdaSync <= 3'h7;
			sdaPrev <= 1'b1;
		end else if (clkEn) begin
			sdaSync <= {sdaSync[1:0], link.sdaLine};
			sdaPrev <= sdaNow;
		end
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= HS_IDLE;
			divCnt <= 8'h0;
			phase <= 2'h0;
			bitCnt <= 4'h0;
			byteIdx <= 2'h0;
			shift <= 8'h0;
			dataReg <= 8'h0;
			addrReg <= 15'h0;
			devReg <= 8'h0;
			readReg <= 1'b0;
			setReg <= 1'b0;
			second <= 1'b0;
			rxPhase <= 1'b0;
			sclOut <= 1'b1;
			sdaOut <= 1'b1;
			rdData <= 8'h0;
			rdValid <= 1'b0;
			nackSeen <= 1'b0;
		end else if (clkEn) begin
			divCnt <= tick ? 8'h0 : 8'(divCnt + 8'h1);
			if (rdValid && rdReady) begin
				rdValid <= 1'b0;
			end
			case (state)
			HS_IDLE: begin
				phase <= 2'h0;
				if (cmdValid && cmdReady) begin
					state <= HS_START;
					devReg <= cmdDevAddr;
					addrReg <= cmdWordAddr;
					dataReg <= cmdData;
					readReg <= cmdRead;
					setReg <= cmdSetAddr;
					second <= 1'b0;
					rxPhase <= 1'b0;
					byteIdx <= 2'h0;
					nackSeen <= 1'b0;
				end
			end
			HS_START, HS_RSTART: begin
				if (tick) begin
					phase <= 2'(phase + 2'h1);
					if (phase == 2'h0) begin
						sdaOut <= 1'b1;
					end else if (phase == 2'h1) begin
						sclOut <= 1'b1;
					end else if (phase == 2'h2) begin
						sdaOut <= 1'b0;
					end else begin
						sclOut <= 1'b0;
						state <= HS_BIT;
						bitCnt <= 4'h0;
						shift <= nextByte;
						phase <= 2'h0;
					end
				end
			end
			HS_BIT: begin
				if (tick) begin
					phase <= 2'(phase + 2'h1);
					if (phase == 2'h0) begin
						sdaOut <= rxPhase ? 1'b1 : shift[7];
					end else if (phase == 2'h1) begin
						sclOut <= 1'b1;
					end else if (phase == 2'h2) begin
						shift <= {shift[6:0], sdaNow};
					end else begin
						sclOut <= 1'b0;
						phase <= 2'h0;
						bitCnt <= 4'(bitCnt + 4'h1);
						if (bitCnt == 4'h7) begin
							state <= HS_ACK;
						end
					end
				end
			end
			HS_ACK: begin
				if (tick) begin
					phase <= 2'(phase + 2'h1);
					if (phase == 2'h0) begin
						sdaOut <= 1'b1;
					end else if (phase == 2'h1) begin
						sclOut <= 1'b1;
						if (sdaNow && !rxPhase) begin
							nackSeen <= 1'b1;
						end
					end else if (phase == 2'h3) begin
						sclOut <= 1'b0;
						phase <= 2'h0;
						bitCnt <= 4'h0;
						if (nackSeen) begin
							state <= HS_STOP;
						end else if (rxPhase) begin
							rdData <= shift;
							rdValid <= 1'b1;
							state <= HS_STOP;
						end else if (readReg && setReg && byteIdx == 2'h2) begin
							second <= 1'b1;
							byteIdx <= 2'h0;
							state <= HS_RSTART;
						end else if (readReg && byteIdx == 2'h0 && (second || !setReg)) begin
							second <= 1'b1;
							rxPhase <= 1'b1;
							state <= HS_BIT;
						end else if (!readReg && byteIdx == 2'h3) begin
							state <= HS_STOP;
						end else begin
							byteIdx <= 2'(byteIdx + 2'h1);
							shift <= (byteIdx == 2'h0) ? {1'b0, addrReg[14:8]}
								: (byteIdx == 2'h1) ? addrReg[7:0] : dataReg;
							state <= HS_BIT;
						end
					end
				end
			end
			HS_STOP: begin
				if (tick) begin
					phase <= 2'(phase + 2'h1);
					if (phase == 2'h0) begin
						sdaOut <= 1'b0;
					end else if (phase == 2'h1) begin
						sclOut <= 1'b1;
					end else if (phase == 2'h2) begin
						sdaOut <= 1'b1;
					end else begin
						state <= HS_DONE;
					end
				end
			end
			default: begin
				state <= HS_IDLE;
			end
			endcase
		end
	end
endmodule

/* bench/twe_link_chk.sv */
// Link checker watching both ends of the two-wire link
`timescale 1ns/1ns
`include "twe_defs.svh"
module twe_link_chk #(
	parameter logic [3:0] TYPE_CODE = `TWE_TYPE_CODE
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sclLine,
	input wire logic sdaLine,
	input wire logic sdaDevOut,
	input wire logic sdaDevOe
);
	logic sclPrev;
	logic sdaPrev;
	logic firstByte;
	logic readDir;
	logic [3:0] bitCnt;
	logic [7:0] shift;
	wire sclRise = sclLine && !sclPrev;
	wire startEv = sclLine && sclPrev && sdaPrev && !sdaLine;
	wire ackEdge = sclRise && bitCnt == 4'h8;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
			firstByte <= 1'b0;
			readDir <= 1'b0;
			bitCnt <= 4'h0;
			shift <= 8'h00;
		end else begin
			sclPrev <= sclLine;
			sdaPrev <= sdaLine;
			if (startEv) begin
				bitCnt <= 4'h0;
				firstByte <= 1'b1;
			end else if (ackEdge) begin
				bitCnt <= 4'h0;
				firstByte <= 1'b0;
			end else if (sclRise) begin
				bitCnt <= bitCnt + 4'h1;
				shift <= {shift[6:0], sdaLine};
			end
			if (sclRise && firstByte && bitCnt == 4'h7) begin
				readDir <= sdaLine;
			end
		end
	end
	////////////////////////////////////////
	sequence s_stop;
		sclLine && $past(sclLine) && $rose(sdaLine);
	endsequence
	sequence s_addr_ack;
		ackEdge && firstByte;
	endsequence
	a_dev_open_drain: assert property (sdaDevOe |-> !sdaDevOut)
		else $error("device drives data line high");
	a_dev_steady_high: assert property (sclLine && $past(sclLine) |-> $stable(sdaDevOe))
		else $error("device changed data while clock high");
	a_match_ack: assert property (s_addr_ack |-> sdaLine || shift[7:4] == TYPE_CODE)
		else $error("foreign device address acknowledged");
	a_mismatch_nack: assert property (s_addr_ack ##0 (shift[7:4] != TYPE_CODE) |-> sdaLine)
		else $error("mismatching address not left unacknowledged");
	a_stop_quiet: assert property (s_stop |=> !sdaDevOe [*8])
		else $error("device drives after stop");
	a_read_nack: assert property (ackEdge && !firstByte && readDir |-> sdaLine)
		else $error("read byte acknowledged by controller");
	a_dev_mack_free: assert property (ackEdge && !firstByte && readDir |-> !sdaDevOe)
		else $error("device holds line in controller ack slot");
	a_write_ack_only: assert property (sclRise && sdaDevOe && !readDir |-> bitCnt == 4'h8)
		else $error("device drives outside ninth clock in write");
	a_addr_bits_free: assert property (sclRise && firstByte && bitCnt < 4'h8 |-> !sdaDevOe)
		else $error("device drives during address word");
endmodule

/* bench/tb_top.sv */
// Bench joining controller and EEPROM over the link
`timescale 1ns/1ns
`include "twe_defs.svh"
module tb_top;
	localparam logic [7:0] DEV = {`TWE_TYPE_CODE, 4'h0};
	logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, wrReady = 1'b1, stall = 1'b0;
	logic cmdValid = 1'b0, cmdRead = 1'b0, cmdSetAddr = 1'b0, rdReady = 1'b0, f;
	logic [7:0] cmdDevAddr = 8'h00, cmdData = 8'h00, mem [logic [14:0]];
	logic [14:0] cmdWordAddr = 15'h0000;
	logic [22:0] w;
	logic [22:0] expQ [$];
	logic [31:0] rnd = 32'h00015cb4;
	wire logic [7:0] rdData, wrData;
	wire logic [14:0] wrAddr;
	wire logic cmdReady, rdValid, nackSeen, wrValid, programming;
	int nErrors = 0, samplesChecked = 0, i, n;
	twe_link_if lnk ();
	twe_host_ctrl #(.SCL_DIV(4)) i_twe_host_ctrl (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
		.link(lnk), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
		.cmdDevAddr(cmdDevAddr), .cmdWordAddr(cmdWordAddr), .cmdData(cmdData),
		.cmdSetAddr(cmdSetAddr), .rdData(rdData), .rdValid(rdValid), .rdReady(rdReady),
		.nackSeen(nackSeen));
	twe_eeprom_dev #(.ADDR_BITS(15), .PROG_CYC(200)) i_twe_eeprom_dev (.mclk(mclk),
		.rst_n(rst_n), .clkEn(clkEn), .link(lnk), .wrData(wrData), .wrAddr(wrAddr),
		.wrValid(wrValid), .wrReady(wrReady), .programming(programming));
	twe_link_chk i_twe_link_chk (.mclk(mclk), .rst_n(rst_n), .sclLine(lnk.sclLine),
		.sdaLine(lnk.sdaLine), .sdaDevOut(lnk.sdaDevOut), .sdaDevOe(lnk.sdaDevOe));
	always #20 mclk = ~mclk;
	////////////////////////////////////////
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	always @(posedge mclk) begin
		rnd <= lfsr_step(rnd);
		clkEn <= rnd[2:0] != 3'h0;
		wrReady <= !stall && rnd[3];
	end
	always @(posedge mclk) begin
		if (rst_n && clkEn && wrValid === 1'b1 && wrReady) begin
			w = expQ.pop_front();
			chk_val("buffer head", w, {wrAddr, wrData});
			mem[w[22:8]] = w[7:0];
		end
	end
	////////////////////////////////////////
	task automatic chk_val(input string what, input logic [22:0] e, input logic [22:0] g);
		samplesChecked++;
		if (g !== e) begin
			nErrors++;
			$display("unexpected %s: expected %h, seen %h", what, e, g);
		end
	endtask
	task automatic chk_flag(input string what, input logic e, input logic g);
		samplesChecked++;
		if (g !== e) begin
			nErrors++;
			$display("unexpected %s: expected %b, seen %b", what, e, g);
		end
	endtask
	task automatic cmd(input logic rd, input logic setA, input logic [7:0] dev,
		input logic [14:0] wa, input logic [7:0] d);
		int k;
		@(posedge mclk);
		cmdValid <= 1'b1;
		cmdRead <= rd;
		cmdSetAddr <= setA;
		cmdDevAddr <= dev;
		cmdWordAddr <= wa;
		cmdData <= d;
		do @(negedge mclk); while (!(cmdReady === 1'b1 && clkEn));
		@(posedge mclk);
		cmdValid <= 1'b0;
		@(negedge mclk);
		for (k = 0; k < 6000 && !(rd ? rdValid === 1'b1 : cmdReady === 1'b1); k++) @(negedge mclk);
		chk_flag("command done", 1'b1, k < 6000);
		if (rd) begin
			chk_val("read data", {15'h0000, mem[wa]}, {15'h0000, rdData});
			@(posedge mclk);
			rdReady <= 1'b1;
			do @(negedge mclk); while (!clkEn);
			@(posedge mclk);
			rdReady <= 1'b0;
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d, output logic firstNack);
		int k;
		expQ.push_back({a, d});
		cmd(1'b0, 1'b0, DEV, a, d);
		firstNack = nackSeen;
		for (k = 0; k < 40 && nackSeen !== 1'b0; k++) cmd(1'b0, 1'b0, DEV, a, d);
		chk_flag("write acked", 1'b0, nackSeen);
	endtask
	task automatic settle();
		for (n = 0; n < 3000 && (programming !== 1'b0 || wrValid !== 1'b0); n++) @(negedge mclk);
		chk_flag("settled", 1'b1, n < 3000);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#(40 * 90000);
		nErrors++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) begin
			settle();
			if (i[3:0] == `TWE_TYPE_CODE) expQ.push_back({15'h0100, 8'h3c});
			cmd(1'b0, 1'b0, {i[3:0], 4'h0}, 15'h0100, 8'h3c);
			chk_flag("address nack", i[3:0] != `TWE_TYPE_CODE, nackSeen);
		end
		settle();
		wr(15'h7fff, 8'ha5, f);
		for (n = 0; n < 20 && programming !== 1'b1; n++) @(negedge mclk);
		chk_flag("programming", 1'b1, programming);
		wr(15'h0000, 8'h5a, f);
		chk_flag("poll refused", 1'b1, f);
		settle();
		cmd(1'b1, 1'b1, DEV, 15'h7fff, 8'h00);
		cmd(1'b1, 1'b0, DEV, 15'h0000, 8'h00);
		wr(15'h013f, 8'hc3, f);
		settle();
		cmd(1'b1, 1'b0, DEV, 15'h0100, 8'h00);
		stall <= 1'b1;
		wr(15'h1000, 8'h11, f);
		wr(15'h1001, 8'h22, f);
		for (n = 0; n < 400 && programming !== 1'b0; n++) @(negedge mclk);
		cmd(1'b0, 1'b0, DEV, 15'h1002, 8'h33);
		chk_flag("full buffer nack", 1'b1, nackSeen);
		stall <= 1'b0;
		for (i = 0; i < 6; i++) begin
			settle();
			wr(rnd[14:0], rnd[22:15], f);
			settle();
			cmd(1'b1, 1'b1, DEV, expQ.size() == 0 ? w[22:8] : 15'h0000, 8'h00);
		end
		settle();
		chk_val("queue left", 23'h000000, 23'(expQ.size()));
		tally_and_finish();
	end
endmodule
